// file: core/ast_core.sv
// Asynchronous serial transceiver: baud generator, FIFOs, transmitter, receiver, events
`timescale 1ns/1ns
//
// Contract
// - Send start, data LSB first, parity, stop
// - Receiver stores error flags with each character
// - Divisor is 16-bit integer plus 6-bit fraction
// - Divisor equals clock over sixteen times baud
// - Tick at sixteen times baud; bits span 16
// - Divisors and line control latched on line write
// - Enabled transmitter drains FIFO with current settings
// - Busy until FIFO empty and stop bits sent
// - Start bit checked on eighth tick
// - Data sampled every 16 ticks, then parity
// - Low stop sample flags framing error
// - Sixteen entries; 12-bit read, 8-bit write
// - FIFOs one deep until FIFO enable set
// - Empty, full and overrun flags reported
// - Selectable trigger levels, half by default
// - Seven events ORed onto one interrupt line
// - Mask gates events; raw shows all
// - Writing one clears the event
// - Timeout after 32 idle bit periods
// - Loopback routes transmit output to receiver
// - Break loads one zero, waits for high
// - Overrun flagged when receive FIFO full
// - Disabling finishes the current character
module ast_core
  import ast_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic serialRxLine,
  output logic serialTxLine,
  input wire logic intDivWrite,
  input wire logic [15:0] intDivData,
  input wire logic fracDivWrite,
  input wire logic [5:0] fracDivData,
  input wire logic lineCtlWrite,
  input wire ast_pkg::ast_lcr_t lineCtlData,
  input wire logic portEnable,
  input wire logic txEnable,
  input wire logic rxEnable,
  input wire logic loopbackEnable,
  input wire logic [2:0] txLevelSelect,
  input wire logic [2:0] rxLevelSelect,
  input wire logic [6:0] eventMaskBits,
  input wire logic [6:0] eventClear,
  input wire logic errorClear,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic rxValid,
  output ast_pkg::ast_rxword_t rxWord,
  input wire logic rxReady,
  output logic txFifoEmpty,
  output logic txFifoFull,
  output logic rxFifoEmpty,
  output logic rxFifoFull,
  output logic busyFlag,
  output logic overrunStatus,
  output logic [6:0] rawEventStatus,
  output logic [6:0] maskedEventStatus,
  output logic interruptRequest
);
  import ast_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration: divisor shadows and the 30-bit working register
  logic [15:0] intDiv_r, intDiv_nxt;
  logic [5:0] fracDiv_r, fracDiv_nxt;
  ast_cfg_t cfg_r, cfg_nxt;
  always_comb begin
    intDiv_nxt = intDivWrite ? intDivData : intDiv_r;
    fracDiv_nxt = fracDivWrite ? fracDivData : fracDiv_r;
    cfg_nxt = cfg_r;
    if (lineCtlWrite) begin
      cfg_nxt = {intDiv_r, fracDiv_r, lineCtlData};
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      intDiv_r <= 16'h0;
      fracDiv_r <= 6'h0;
      cfg_r <= AST_CFG_RESET;
    end else begin
      intDiv_r <= intDiv_nxt;
      fracDiv_r <= fracDiv_nxt;
      cfg_r <= cfg_nxt;
    end
  end
  wire logic [4:0] capacity = cfg_r.lcr.fifoEnable ? 5'(AST_FIFO_DEPTH) : 5'h01;
  wire logic [2:0] lastBit = AST_MIN_WORD_BITS + {1'b0, cfg_r.lcr.wordLen};
  wire logic [7:0] dataMask = 8'(8'hff >> (2'h3 - cfg_r.lcr.wordLen));

  ////////////////////////////////////////////////////////////////////////////////
  // Oversample tick generator with fractional stretch
  logic [16:0] baudCnt_r, baudCnt_nxt;
  logic [5:0] fracAcc_r, fracAcc_nxt;
  logic stretch_r, stretch_nxt, oversampleTick_r, tick_nxt;
  logic [6:0] fracSum;
  logic [16:0] baudLimit;
  always_comb begin
    fracSum = {1'b0, fracAcc_r} + {1'b0, cfg_r.divisorFractionPart};
    baudLimit = {1'b0, cfg_r.divisorIntegerPart} - 17'h1 + {16'h0, stretch_r};
    baudCnt_nxt = baudCnt_r + 17'h1;
    fracAcc_nxt = fracAcc_r;
    stretch_nxt = stretch_r;
    tick_nxt = 1'b0;
    if (cfg_r.divisorIntegerPart == 16'h0) begin
      baudCnt_nxt = 17'h0;
    end else if (baudCnt_r >= baudLimit) begin
      baudCnt_nxt = 17'h0;
      tick_nxt = 1'b1;
      fracAcc_nxt = fracSum[5:0];
      stretch_nxt = fracSum[6];
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      baudCnt_r <= 17'h0;
      fracAcc_r <= 6'h0;
      stretch_r <= 1'b0;
      oversampleTick_r <= 1'b0;
    end else begin
      baudCnt_r <= baudCnt_nxt;
      fracAcc_r <= fracAcc_nxt;
      stretch_r <= stretch_nxt;
      oversampleTick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO and transmitter
  logic [7:0] txMem [AST_FIFO_DEPTH];
  logic [AST_PTR_W-1:0] txWp_r, txWp_nxt, txRp_r, txRp_nxt;
  logic [AST_CNT_W-1:0] txCnt_r, txCnt_nxt;
  ast_txst_t txSt_r, txSt_nxt;
  logic [3:0] txSub_r, txSub_nxt;
  logic [2:0] txIdx_r, txIdx_nxt;
  logic [7:0] txShift_r, txShift_nxt;
  logic txPar_r, txPar_nxt, txLine_nxt, txPush, txPop, txStep;
  always_comb begin
    txPush = txValid && txReady;
    txPop = 1'b0;
    txSt_nxt = txSt_r;
    txSub_nxt = txSub_r;
    txIdx_nxt = txIdx_r;
    txShift_nxt = txShift_r;
    txPar_nxt = txPar_r;
    txStep = oversampleTick_r && txSub_r == AST_TICKS_PER_BIT_LAST;
    if (oversampleTick_r && txSt_r != AST_TX_IDLE) begin
      txSub_nxt = txSub_r + 4'h1;
    end
    unique case (txSt_r)
      AST_TX_IDLE: begin
        if (txCnt_r != 5'h0 && portEnable && txEnable) begin
          txPop = 1'b1;
          txShift_nxt = txMem[txRp_r];
          txPar_nxt = cfg_r.lcr.stickParity ? !cfg_r.lcr.evenParity
                    : (^(txMem[txRp_r] & dataMask)) ^ !cfg_r.lcr.evenParity;
          txSub_nxt = 4'h0;
          txSt_nxt = AST_TX_START;
        end
      end
      AST_TX_START: if (txStep) begin
        txIdx_nxt = 3'h0;
        txSt_nxt = AST_TX_DATA;
      end
      AST_TX_DATA: if (txStep) begin
        txShift_nxt = {1'b0, txShift_r[7:1]};
        txIdx_nxt = txIdx_r + 3'h1;
        if (txIdx_r == lastBit) begin
          txIdx_nxt = 3'h0;
          txSt_nxt = cfg_r.lcr.parityEnable ? AST_TX_PARITY : AST_TX_STOP;
        end
      end
      AST_TX_PARITY: if (txStep) begin
        txSt_nxt = AST_TX_STOP;
      end
      AST_TX_STOP: if (txStep) begin
        txIdx_nxt = 3'h1;
        if (!cfg_r.lcr.twoStop || txIdx_r != 3'h0) begin
          txSt_nxt = AST_TX_IDLE;
        end
      end
    endcase
    unique case (txSt_nxt)
      AST_TX_START: txLine_nxt = 1'b0;
      AST_TX_DATA: txLine_nxt = txShift_nxt[0];
      AST_TX_PARITY: txLine_nxt = txPar_nxt;
      default: txLine_nxt = 1'b1;
    endcase
    if (cfg_r.lcr.sendBreak) begin
      txLine_nxt = 1'b0;
    end
    txWp_nxt = txPush ? txWp_r + 4'h1 : txWp_r;
    txRp_nxt = txPop ? txRp_r + 4'h1 : txRp_r;
    txCnt_nxt = txCnt_r + {4'h0, txPush} - {4'h0, txPop};
  end
  always_ff @(posedge clock) begin
    if (txPush) begin
      txMem[txWp_r] <= txData;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      txSt_r <= AST_TX_IDLE;
      txSub_r <= 4'h0;
      txIdx_r <= 3'h0;
      txShift_r <= 8'h0;
      txPar_r <= 1'b0;
      serialTxLine <= 1'b1;
      txWp_r <= 4'h0;
      txRp_r <= 4'h0;
      txCnt_r <= 5'h0;
      txReady <= 1'b1;
      txFifoEmpty <= 1'b1;
      txFifoFull <= 1'b0;
      busyFlag <= 1'b0;
    end else begin
      txSt_r <= txSt_nxt;
      txSub_r <= txSub_nxt;
      txIdx_r <= txIdx_nxt;
      txShift_r <= txShift_nxt;
      txPar_r <= txPar_nxt;
      serialTxLine <= txLine_nxt;
      txWp_r <= txWp_nxt;
      txRp_r <= txRp_nxt;
      txCnt_r <= txCnt_nxt;
      txReady <= txCnt_nxt < capacity;
      txFifoEmpty <= txCnt_nxt == 5'h0;
      txFifoFull <= txCnt_nxt >= capacity;
      busyFlag <= txCnt_nxt != 5'h0 || txSt_nxt != AST_TX_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive line synchroniser and receiver
  logic sync1_r, sync2_r, sync3_r, rxIn_r, rxIn_nxt;
  always_comb begin
    rxIn_nxt = (sync2_r == sync3_r) ? sync3_r : rxIn_r;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
      rxIn_r <= 1'b1;
    end else begin
      sync1_r <= serialRxLine;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      rxIn_r <= rxIn_nxt;
    end
  end
  wire logic rxBit = loopbackEnable ? serialTxLine : rxIn_r;

  ast_rxst_t rxSt_r, rxSt_nxt;
  logic [3:0] rxSub_r, rxSub_nxt;
  logic [2:0] rxIdx_r, rxIdx_nxt;
  logic [7:0] rxShift_r, rxShift_nxt, rxData;
  logic rxParErr_r, rxParErr_nxt, rxLow_r, rxLow_nxt, rxPush, rxSample;
  ast_rxword_t rxIn;
  always_comb begin
    rxSt_nxt = rxSt_r;
    rxSub_nxt = rxSub_r;
    rxIdx_nxt = rxIdx_r;
    rxShift_nxt = rxShift_r;
    rxParErr_nxt = rxParErr_r;
    rxLow_nxt = rxLow_r;
    rxPush = 1'b0;
    rxData = 8'(rxShift_r >> (2'h3 - cfg_r.lcr.wordLen));
    rxIn = {1'b0, 1'b0, rxParErr_r, !rxBit, rxData};
    rxSample = oversampleTick_r && rxSub_r == AST_TICKS_PER_BIT_LAST;
    if (oversampleTick_r) begin
      rxSub_nxt = rxSub_r + 4'h1;
    end
    if (rxSample) begin
      rxLow_nxt = rxLow_r && !rxBit;
    end
    unique case (rxSt_r)
      AST_RX_IDLE: begin
        rxSub_nxt = 4'h0;
        if (!rxBit && portEnable && rxEnable) begin
          rxSt_nxt = AST_RX_START;
        end
      end
      AST_RX_START: if (oversampleTick_r && rxSub_r == AST_START_SAMPLE) begin
        rxSub_nxt = 4'h0;
        rxIdx_nxt = 3'h0;
        rxLow_nxt = 1'b1;
        rxParErr_nxt = 1'b0;
        rxSt_nxt = rxBit ? AST_RX_IDLE : AST_RX_DATA;
      end
      AST_RX_DATA: if (rxSample) begin
        rxShift_nxt = {rxBit, rxShift_r[7:1]};
        rxIdx_nxt = rxIdx_r + 3'h1;
        if (rxIdx_r == lastBit) begin
          rxSt_nxt = cfg_r.lcr.parityEnable ? AST_RX_PARITY : AST_RX_STOP;
        end
      end
      AST_RX_PARITY: if (rxSample) begin
        rxParErr_nxt = rxBit != (cfg_r.lcr.stickParity ? !cfg_r.lcr.evenParity
                     : (^rxData) ^ !cfg_r.lcr.evenParity);
        rxSt_nxt = AST_RX_STOP;
      end
      AST_RX_STOP: if (rxSample) begin
        rxPush = 1'b1;
        rxSt_nxt = AST_RX_IDLE;
        if (rxLow_r && !rxBit) begin
          rxIn = {1'b0, 1'b1, 1'b0, 1'b1, 8'h00};
          rxSt_nxt = AST_RX_BRKWAIT;
        end
      end
      AST_RX_BRKWAIT: if (rxBit) begin
        rxSt_nxt = AST_RX_IDLE;
      end
      default: rxSt_nxt = AST_RX_IDLE;
    endcase
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rxSt_r <= AST_RX_IDLE;
      rxSub_r <= 4'h0;
      rxIdx_r <= 3'h0;
      rxShift_r <= 8'h0;
      rxParErr_r <= 1'b0;
      rxLow_r <= 1'b0;
    end else begin
      rxSt_r <= rxSt_nxt;
      rxSub_r <= rxSub_nxt;
      rxIdx_r <= rxIdx_nxt;
      rxShift_r <= rxShift_nxt;
      rxParErr_r <= rxParErr_nxt;
      rxLow_r <= rxLow_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive FIFO, two-entry output buffer and overrun
  ast_rxword_t rxMem [AST_FIFO_DEPTH];
  ast_rxword_t outBuf_r [2];
  ast_rxword_t outBuf_nxt [2];
  logic [AST_PTR_W-1:0] rxWp_r, rxWp_nxt, rxRp_r, rxRp_nxt;
  logic [AST_CNT_W-1:0] rxCnt_r, rxCnt_nxt, occ_nxt;
  logic [1:0] bufCnt_r, bufCnt_nxt;
  logic ovPend_r, ovPend_nxt, ovStat_nxt, rxStore, rxDrop, rxMove, bufPop;
  ast_rxword_t rxStoreWord;
  always_comb begin
    rxDrop = rxPush && rxCnt_r >= capacity;
    rxStore = rxPush && !rxDrop;
    rxStoreWord = rxIn;
    rxStoreWord.overrunErr = ovPend_r;
    ovPend_nxt = rxDrop || (ovPend_r && !rxStore);
    ovStat_nxt = rxDrop || (overrunStatus && !errorClear);
    bufPop = rxValid && rxReady;
    outBuf_nxt = outBuf_r;
    bufCnt_nxt = bufCnt_r - {1'b0, bufPop};
    if (bufPop) begin
      outBuf_nxt[0] = outBuf_r[1];
    end
    rxMove = rxCnt_r != 5'h0 && bufCnt_nxt != 2'h2;
    if (rxMove) begin
      outBuf_nxt[bufCnt_nxt[0]] = rxMem[rxRp_r];
      bufCnt_nxt = bufCnt_nxt + 2'h1;
    end
    rxWp_nxt = rxStore ? rxWp_r + 4'h1 : rxWp_r;
    rxRp_nxt = rxMove ? rxRp_r + 4'h1 : rxRp_r;
    rxCnt_nxt = rxCnt_r + {4'h0, rxStore} - {4'h0, rxMove};
    occ_nxt = rxCnt_nxt + {3'h0, bufCnt_nxt};
  end
  always_ff @(posedge clock) begin
    if (rxStore) begin
      rxMem[rxWp_r] <= rxStoreWord;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      outBuf_r[0] <= 12'h0;
      outBuf_r[1] <= 12'h0;
      bufCnt_r <= 2'h0;
      rxWp_r <= 4'h0;
      rxRp_r <= 4'h0;
      rxCnt_r <= 5'h0;
      ovPend_r <= 1'b0;
      overrunStatus <= 1'b0;
      rxValid <= 1'b0;
      rxFifoEmpty <= 1'b1;
      rxFifoFull <= 1'b0;
    end else begin
      outBuf_r <= outBuf_nxt;
      bufCnt_r <= bufCnt_nxt;
      rxWp_r <= rxWp_nxt;
      rxRp_r <= rxRp_nxt;
      rxCnt_r <= rxCnt_nxt;
      ovPend_r <= ovPend_nxt;
      overrunStatus <= ovStat_nxt;
      rxValid <= bufCnt_nxt != 2'h0;
      rxFifoEmpty <= occ_nxt == 5'h0;
      rxFifoFull <= rxCnt_nxt >= capacity;
    end
  end
  assign rxWord = outBuf_r[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Events, timeout and interrupt
  logic [9:0] rtCnt_r, rtCnt_nxt;
  logic txMet_r, txMet_nxt, rxMet_r, rxMet_nxt, rtHit;
  logic [AST_EV_W-1:0] setVec, raw_nxt, masked_nxt;
  wire logic [4:0] occ = rxCnt_r + {3'h0, bufCnt_r};
  always_comb begin
    txMet_nxt = cfg_r.lcr.fifoEnable ? txCnt_r <= ast_level(txLevelSelect)
              : txCnt_r == 5'h0;
    rxMet_nxt = cfg_r.lcr.fifoEnable ? occ >= ast_level(rxLevelSelect)
              : occ != 5'h0;
    rtCnt_nxt = rtCnt_r;
    if (rxPush || occ == 5'h0) begin
      rtCnt_nxt = 10'h0;
    end else if (oversampleTick_r && rtCnt_r != AST_TIMEOUT_TICKS) begin
      rtCnt_nxt = rtCnt_r + 10'h1;
    end
    rtHit = rtCnt_r != AST_TIMEOUT_TICKS && rtCnt_nxt == AST_TIMEOUT_TICKS;
    setVec = '0;
    setVec[AST_EV_RX] = rxMet_nxt && !rxMet_r;
    setVec[AST_EV_TX] = txMet_nxt && !txMet_r;
    setVec[AST_EV_RT] = rtHit;
    setVec[AST_EV_FE] = rxStore && rxStoreWord.frameErr;
    setVec[AST_EV_PE] = rxStore && rxStoreWord.parityErr;
    setVec[AST_EV_BE] = rxStore && rxStoreWord.breakErr;
    setVec[AST_EV_OE] = rxDrop;
    raw_nxt = (rawEventStatus & ~eventClear) | setVec;
    if (occ == 5'h0) begin
      raw_nxt[AST_EV_RT] = 1'b0;
    end
    masked_nxt = raw_nxt & eventMaskBits;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rtCnt_r <= 10'h0;
      txMet_r <= 1'b0;
      rxMet_r <= 1'b0;
      rawEventStatus <= 7'h0;
      maskedEventStatus <= 7'h0;
      interruptRequest <= 1'b0;
    end else begin
      rtCnt_r <= rtCnt_nxt;
      txMet_r <= txMet_nxt;
      rxMet_r <= rxMet_nxt;
      rawEventStatus <= raw_nxt;
      maskedEventStatus <= masked_nxt;
      interruptRequest <= |masked_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  busy_hold_a: assert property (@(posedge clock) disable iff (reset)
    txCnt_r != 5'h0 || txSt_r != AST_TX_IDLE |-> busyFlag) else $error("busy low early");
  start_low_a: assert property (@(posedge clock) disable iff (reset)
    txSt_r == AST_TX_START && !cfg_r.lcr.sendBreak |-> !serialTxLine)
    else $error("start bit not low");
  stop_high_a: assert property (@(posedge clock) disable iff (reset)
    txSt_r == AST_TX_STOP && !cfg_r.lcr.sendBreak |-> serialTxLine)
    else $error("stop bit not high");
  cfg_latch_a: assert property (@(posedge clock) disable iff (reset)
    !lineCtlWrite |=> $stable(cfg_r)) else $error("config changed without line write");
  tick_space_a: assert property (@(posedge clock) disable iff (reset)
    oversampleTick_r && cfg_r.divisorIntegerPart > 16'h2 && !lineCtlWrite
    |=> !oversampleTick_r [*2]) else $error("tick period too short");
  false_start_a: assert property (@(posedge clock) disable iff (reset)
    rxSt_r == AST_RX_START && oversampleTick_r && rxSub_r == AST_START_SAMPLE && rxBit
    |=> rxSt_r == AST_RX_IDLE) else $error("false start accepted");
  overrun_flag_a: assert property (@(posedge clock) disable iff (reset)
    rxPush && rxCnt_r >= capacity
    |=> overrunStatus && rxCnt_r == $past(rxCnt_r) - 5'($past(rxMove)))
    else $error("overrun missed");
  irq_mask_a: assert property (@(posedge clock) disable iff (reset)
    interruptRequest == |(rawEventStatus & $past(eventMaskBits))) else $error("irq mismatch");
  clear_ev_a: assert property (@(posedge clock) disable iff (reset)
    ##1 (rawEventStatus & $past(eventClear) & ~$past(setVec)) == 7'h0)
    else $error("event not cleared");
  tx_frame_c: cover property (@(posedge clock) txSt_r == AST_TX_STOP ##1 txSt_r == AST_TX_IDLE);
  rx_word_c: cover property (@(posedge clock) rxStore && !rxIn.frameErr);
  rx_break_c: cover property (@(posedge clock) rxSt_r == AST_RX_BRKWAIT);
  rx_timeout_c: cover property (@(posedge clock) rtHit);
endmodule

// file: common/ast_pkg.sv
// Shared constants and types of the asynchronous serial transceiver
package ast_pkg;
  localparam int AST_FIFO_DEPTH = 16;
  localparam int AST_PTR_W = 4;
  localparam int AST_CNT_W = 5;
  localparam int AST_EV_W = 7;
  localparam int CLOCK_HZ = 50000000;
  localparam logic [3:0] AST_TICKS_PER_BIT_LAST = 4'hf;
  localparam logic [3:0] AST_START_SAMPLE = 4'h7;
  localparam int AST_TIMEOUT_BITS = 32;
  localparam logic [9:0] AST_TIMEOUT_TICKS = 10'(AST_TIMEOUT_BITS * 16);
  localparam logic [2:0] AST_LEVEL_RESET = 3'h2;
  localparam logic [2:0] AST_MIN_WORD_BITS = 3'h4;
  // Event bit positions
  localparam int AST_EV_RX = 0;
  localparam int AST_EV_TX = 1;
  localparam int AST_EV_RT = 2;
  localparam int AST_EV_FE = 3;
  localparam int AST_EV_PE = 4;
  localparam int AST_EV_BE = 5;
  localparam int AST_EV_OE = 6;

  typedef struct packed {
    logic stickParity;
    logic [1:0] wordLen;
    logic fifoEnable;
    logic twoStop;
    logic evenParity;
    logic parityEnable;
    logic sendBreak;
  } ast_lcr_t;

  typedef struct packed {
    logic [15:0] divisorIntegerPart;
    logic [5:0] divisorFractionPart;
    ast_lcr_t lcr;
  } ast_cfg_t;

  typedef struct packed {
    logic overrunErr;
    logic breakErr;
    logic parityErr;
    logic frameErr;
    logic [7:0] data;
  } ast_rxword_t;

  localparam ast_cfg_t AST_CFG_RESET = 30'h0;

  typedef enum logic [2:0] {
    AST_TX_IDLE = 3'b000, AST_TX_START = 3'b001, AST_TX_DATA = 3'b010,
    AST_TX_PARITY = 3'b011, AST_TX_STOP = 3'b100
  } ast_txst_t;

  typedef enum logic [2:0] {
    AST_RX_IDLE = 3'b000, AST_RX_START = 3'b001, AST_RX_DATA = 3'b010,
    AST_RX_PARITY = 3'b011, AST_RX_STOP = 3'b100, AST_RX_BRKWAIT = 3'b101
  } ast_rxst_t;

  // Trigger level in entries for 1/8, 1/4, 1/2, 3/4, 7/8
  function automatic logic [4:0] ast_level(input logic [2:0] sel);
    case (sel)
      3'h0: ast_level = 5'h02;
      3'h1: ast_level = 5'h04;
      3'h3: ast_level = 5'h0c;
      3'h4: ast_level = 5'h0e;
      default: ast_level = 5'h08;
    endcase
  endfunction
endpackage

// file: verif/ast_peer.sv
// Remote serial device model: 8 data bits, one stop bit, 16 clocks a bit
`timescale 1ns/1ns
module ast_peer (
  input wire logic clock,
  input wire logic lineIn,
  output logic lineOut
);
  logic [7:0] gotByte = 8'h00;
  int gotCnt = 0;
  initial lineOut = 1'b1;
  task automatic bitFor(input logic v);
    lineOut = v;
    repeat (16) @(posedge clock);
    #1;
  endtask
  // Start low, data LSB first, then the chosen stop level
  task automatic sendFrame(input logic [7:0] d, input logic stopLvl);
    @(posedge clock);
    #1;
    bitFor(1'b0);
    for (int i = 0; i < 8; i++) bitFor(d[i]);
    bitFor(stopLvl);
    lineOut = 1'b1;
  endtask
  // Sample mid-bit, counting the frame at the stop sample
  always begin
    @(negedge lineIn);
    repeat (8) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clock);
      gotByte[i] = lineIn;
    end
    repeat (16) @(posedge clock);
    gotCnt++;
  end
endmodule

// file: verif/async_serial_transceiver_tb_top.sv
// Self-checking bench of the serial transceiver
`timescale 1ns/1ns
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin numErrors++; \
  $display("unexpected at %0t: value mismatch", $time); end end
module async_serial_transceiver_tb_top import ast_pkg::*;;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic intDivWrite = 1'b0, fracDivWrite = 1'b0, lineCtlWrite = 1'b0;
  logic [15:0] intDivData = 16'h0000;
  logic [5:0] fracDivData = 6'h00;
  ast_lcr_t lineCtlData = ast_lcr_t'(8'h00);
  logic portEnable = 1'b1, txEnable = 1'b1, rxEnable = 1'b1, loopbackEnable = 1'b0;
  logic [6:0] eventMaskBits = 7'h00, eventClear = 7'h00;
  logic txValid = 1'b0, rxReady = 1'b0, errorClear = 1'b0;
  logic [7:0] txData = 8'h00;
  logic serialRxLine, serialTxLine, txReady, rxValid, txFifoEmpty, txFifoFull;
  logic rxFifoEmpty, rxFifoFull, busyFlag, overrunStatus, interruptRequest;
  logic [6:0] rawEventStatus, maskedEventStatus;
  ast_rxword_t rxWord;
  int numErrors = 0, nCompared = 0, expCnt = 0;
  always #10 clock = ~clock;
  ast_core dut (.clock(clock), .reset(reset), .serialRxLine(serialRxLine),
    .serialTxLine(serialTxLine), .intDivWrite(intDivWrite), .intDivData(intDivData),
    .fracDivWrite(fracDivWrite), .fracDivData(fracDivData), .lineCtlWrite(lineCtlWrite),
    .lineCtlData(lineCtlData), .portEnable(portEnable), .txEnable(txEnable),
    .rxEnable(rxEnable), .loopbackEnable(loopbackEnable), .txLevelSelect(3'h2),
    .rxLevelSelect(3'h2), .eventMaskBits(eventMaskBits), .eventClear(eventClear),
    .errorClear(errorClear), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxValid(rxValid), .rxWord(rxWord), .rxReady(rxReady), .txFifoEmpty(txFifoEmpty),
    .txFifoFull(txFifoFull), .rxFifoEmpty(rxFifoEmpty), .rxFifoFull(rxFifoFull),
    .busyFlag(busyFlag), .overrunStatus(overrunStatus), .rawEventStatus(rawEventStatus),
    .maskedEventStatus(maskedEventStatus), .interruptRequest(interruptRequest));
  ast_peer peer (.clock(clock), .lineIn(serialTxLine), .lineOut(serialRxLine));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Let one edge pass, wait until the FIFO accepts, then push exactly once
  task automatic pushTx(input logic [7:0] d);
    tick(1);
    for (int n = 0; n < 2000 && txReady !== 1'b1; n++) tick(1);
    txValid = 1'b1;
    txData = d;
    tick(1);
    txValid = 1'b0;
  endtask
  task automatic popRx(input logic [11:0] exp);
    tick(1);
    for (int n = 0; n < 600 && rxValid !== 1'b1; n++) tick(1);
    `CHK(rxValid, 1'b1)
    `CHK(rxWord, exp)
    rxReady = 1'b1;
    tick(1);
    rxReady = 1'b0;
  endtask
  task automatic waitIdle(input int lim);
    for (int n = 0; n < lim && busyFlag !== 1'b0; n++) tick(1);
  endtask
  task automatic completeRun;
    $display("Errors %0d, compared %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic testEvents;
    tick(2);
    `CHK(txFifoEmpty, 1'b1)
    `CHK(rxFifoEmpty, 1'b1)
    `CHK(rawEventStatus, 7'h02)
    `CHK(interruptRequest, 1'b0)
    eventMaskBits = 7'h02;
    tick(1);
    `CHK(maskedEventStatus, 7'h02)
    `CHK(interruptRequest, 1'b1)
    eventClear = 7'h02;
    tick(1);
    eventClear = 7'h00;
    tick(1);
    `CHK(rawEventStatus[AST_EV_TX], 1'b0)
    `CHK(interruptRequest, 1'b0)
  endtask
  // Latch divisor 1; a later divisor write alone must leave the bit time alone
  task automatic testLatchAndSend;
    intDivWrite = 1'b1;
    intDivData = 16'h0001;
    fracDivWrite = 1'b1;
    tick(1);
    intDivWrite = 1'b0;
    fracDivWrite = 1'b0;
    lineCtlWrite = 1'b1;
    lineCtlData = ast_lcr_t'(8'h70);
    tick(1);
    lineCtlWrite = 1'b0;
    intDivWrite = 1'b1;
    intDivData = 16'h0003;
    tick(1);
    intDivWrite = 1'b0;
    pushTx(8'ha5);
    `CHK(busyFlag, 1'b1)
    `CHK(txReady, 1'b1)
    expCnt++;
    for (int n = 0; n < 400 && peer.gotCnt != expCnt; n++) tick(1);
    `CHK(peer.gotByte, 8'ha5)
    `CHK(busyFlag, 1'b1)
    waitIdle(20);
    `CHK(busyFlag, 1'b0)
    `CHK(serialTxLine, 1'b1)
  endtask
  task automatic testReceive;
    peer.sendFrame(8'h3c, 1'b1);
    popRx(12'h03c);
    peer.sendFrame(8'hc3, 1'b0);
    popRx(12'h1c3);
    peer.lineOut = 1'b0;
    tick(4);
    peer.lineOut = 1'b1;
    tick(200);
    `CHK(rxValid, 1'b0)
    peer.lineOut = 1'b0;
    tick(400);
    peer.lineOut = 1'b1;
    popRx(12'h500);
    tick(50);
    `CHK(rxValid, 1'b0)
  endtask
  // Hold the request up for 20 cycles, past the point the FIFO refuses, then let it drain
  task automatic testFill;
    int cnt;
    cnt = 0;
    txValid = 1'b1;
    txData = 8'h81;
    for (int k = 0; k < 20; k++) begin
      if (txReady === 1'b1) cnt++;
      tick(1);
    end
    txValid = 1'b0;
    `CHK(txFifoFull, 1'b1)
    `CHK(cnt >= 16, 1'b1)
    waitIdle(3500);
    expCnt += cnt;
    `CHK(peer.gotCnt, expCnt)
    `CHK(peer.gotByte, 8'h81)
  endtask
  task automatic testLoop;
    loopbackEnable = 1'b1;
    pushTx(8'h5a);
    popRx(12'h05a);
    loopbackEnable = 1'b0;
  endtask
  // One-deep FIFOs at divisor 3 over loopback: the fourth word is lost
  task automatic testOverrun;
    loopbackEnable = 1'b1;
    lineCtlWrite = 1'b1;
    lineCtlData = ast_lcr_t'(8'h60);
    tick(1);
    lineCtlWrite = 1'b0;
    for (int k = 0; k < 4; k++) begin
      pushTx(8'h11 + 8'(k));
      `CHK(txReady, 1'b0)
    end
    waitIdle(1500);
    `CHK(overrunStatus, 1'b1)
    `CHK(rxFifoFull, 1'b1)
    `CHK(rawEventStatus[AST_EV_OE], 1'b1)
    popRx(12'h011);
    popRx(12'h012);
    popRx(12'h013);
    `CHK(rxFifoEmpty, 1'b1)
    errorClear = 1'b1;
    tick(1);
    errorClear = 1'b0;
    `CHK(overrunStatus, 1'b0)
    loopbackEnable = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock);
    #1;
    reset = 1'b0;
    testEvents();
    testLatchAndSend();
    testReceive();
    testFill();
    testLoop();
    testOverrun();
    completeRun();
  end
  initial begin
    #(20 * 20000);
    numErrors++;
    completeRun();
  end
endmodule
